// ### hdl/sae_pkg.sv
// shared constants and helpers for the serial-gmii ability exchange block
// assumes word-indexed register addresses and 16-bit management data
package sae_pkg;

  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;

  // word offsets
  localparam logic [4:0] OFF_STATUS    = 5'h01;
  localparam logic [4:0] OFF_LOCAL     = 5'h04;
  localparam logic [4:0] OFF_PEER      = 5'h05;
  localparam logic [4:0] OFF_EXPANSION = 5'h06;
  localparam logic [4:0] OFF_MODE      = 5'h14;

  // ability word fields
  localparam int AB_ZERO_BIT   = 0;
  localparam int AB_SPEED_LO   = 10;
  localparam int AB_DUPLEX_BIT = 12;
  localparam int AB_ACK_BIT    = 14;
  localparam int AB_LINK_BIT   = 15;
  // bits that carry a function in a serial-gmii ability word
  localparam logic [15:0] AB_LIVE_MASK = 16'hdc00;

  localparam logic [15:0] MAC_FIXED_WORD = 16'h4001;

  // speed codes
  localparam logic [1:0] SPEED_10M  = 2'h0;
  localparam logic [1:0] SPEED_100M = 2'h1;
  localparam logic [1:0] SPEED_1G   = 2'h2;
  localparam logic [1:0] SPEED_RSVD = 2'h3;

  // mode register fields
  localparam int MODE_SGMII_BIT  = 0;
  localparam int MODE_ADOPT_BIT  = 1;
  localparam int MODE_SPEED_LO   = 2;
  localparam int MODE_HALF_BIT   = 4;
  localparam int MODE_ROLE_BIT   = 5;
  localparam logic [5:0] MODE_WRITE_MASK = 6'h3f;

  // status and expansion fields
  localparam int STAT_DONE_BIT   = 5;
  localparam int EXP_ABLE_BIT    = 0;
  localparam int EXP_PAGE_BIT    = 1;

  // reset values
  localparam logic [5:0]  MODE_RESET  = 6'h00;
  localparam logic [15:0] LOCAL_RESET = 16'h0001;
  localparam logic [15:0] PEER_RESET  = 16'h0000;

  function automatic logic [1:0] ability_speed(input logic [15:0] word);
    ability_speed = word[AB_SPEED_LO +: 2];
  endfunction

  function automatic logic ability_full_duplex(input logic [15:0] word);
    ability_full_duplex = word[AB_DUPLEX_BIT];
  endfunction

endpackage

// ### hdl/sae_cfg_if.sv
// configuration carried from the mode/local-ability registers to the resolver
// assumes one clock domain; pure wiring
`timescale 1ns/1ns
interface sae_cfg_if;
  logic        sgmii_sel;
  logic        adopt_peer;
  logic [1:0]  manual_speed;
  logic        manual_half;
  logic        role_phy;
  logic [15:0] local_word;

  modport regs (
    output sgmii_sel,
    output adopt_peer,
    output manual_speed,
    output manual_half,
    output role_phy,
    output local_word
  );

  modport res (
    input sgmii_sel,
    input adopt_peer,
    input manual_speed,
    input manual_half,
    input role_phy,
    input local_word
  );
endinterface

// ### hdl/sae_mode_regs.sv
// interface mode and local ability storage written by management software
// assumes one-cycle write strobes on the plain register port
`timescale 1ns/1ns
module sae_mode_regs
  import sae_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic              wr_in,
  output logic [5:0]             mode_out,
  sae_cfg_if.regs                cfg
);

  logic [5:0]  mode_q;
  logic [15:0] local_q;
  wire         mode_wr  = wr_in && (addr_in == OFF_MODE);
  wire         local_wr = wr_in && (addr_in == OFF_LOCAL);

  // the stored value is kept even in mac role; only the link word is replaced
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      mode_q  <= MODE_RESET;
      local_q <= LOCAL_RESET;
    end
    else
    begin
      if (mode_wr)
        mode_q <= wdata_in[5:0] & MODE_WRITE_MASK;
      if (local_wr)
        local_q <= wdata_in;
    end
  end

  assign mode_out          = mode_q;
  assign cfg.sgmii_sel     = mode_q[MODE_SGMII_BIT];
  assign cfg.adopt_peer    = mode_q[MODE_ADOPT_BIT];
  assign cfg.manual_speed  = mode_q[MODE_SPEED_LO +: 2];
  assign cfg.manual_half   = mode_q[MODE_HALF_BIT];
  assign cfg.role_phy      = mode_q[MODE_ROLE_BIT];
  assign cfg.local_word    = local_q;

endmodule

// ### hdl/sae_resolve.sv
// speed and duplex resolution: adopt mode waits for negotiation to finish, other modes load every cycle
// assumes peer word and done flag are already registered in the caller
`timescale 1ns/1ns
module sae_resolve
  import sae_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        an_done_in,
  input  wire logic [15:0] peer_word_in,
  sae_cfg_if.res           cfg,
  output logic [1:0]       speed_out,
  output logic             full_duplex_out,
  output logic             link_up_out,
  output logic             valid_out
);

  logic [1:0]  speed_q;
  logic        fd_q;
  logic        link_q;
  logic        valid_q;

  // mac role trusts the partner, phy role trusts what software wrote
  wire [15:0] src_word = cfg.role_phy ? cfg.local_word : peer_word_in;
  wire        auto_res = cfg.sgmii_sel && cfg.adopt_peer;
  wire        res_now  = auto_res && an_done_in;
  wire [1:0]  speed_d  = !cfg.sgmii_sel ? SPEED_1G :
                         auto_res ? ability_speed(src_word) : cfg.manual_speed;
  wire        fd_d     = !cfg.sgmii_sel ? 1'b1 :
                         auto_res ? ability_full_duplex(src_word) : !cfg.manual_half;
  wire        link_d   = auto_res ? src_word[AB_LINK_BIT] : 1'b1;
  wire        load     = !auto_res || res_now;

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      speed_q <= SPEED_1G;
      fd_q    <= 1'b1;
      link_q  <= 1'b0;
      valid_q <= 1'b0;
    end
    else
    begin
      valid_q <= load;
      if (load)
      begin
        speed_q <= speed_d;
        fd_q    <= fd_d;
        link_q  <= link_d;
      end
    end
  end

  assign speed_out       = speed_q;
  assign full_duplex_out = fd_q;
  assign link_up_out     = link_q;
  assign valid_out       = valid_q;

endmodule

// ### hdl/sae_ability_exchange.sv
// serial-gmii ability word exchange: advertised word, peer capture,
// expansion status and speed/duplex resolution
// assumes the negotiation state machine outside supplies pages and done
`timescale 1ns/1ns
module sae_ability_exchange
  import sae_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  // management port
  input  wire logic [ADDR_W-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  input  wire logic              wr_in,
  input  wire logic              rd_in,
  output logic [DATA_W-1:0]      rdata_out,
  // negotiation engine side
  input  wire logic [15:0]       rx_word_in,
  input  wire logic              rx_page_in,
  input  wire logic              partner_able_in,
  input  wire logic              local_ack_in,
  input  wire logic              an_done_in,
  output logic [15:0]            tx_word_out,
  // resolved operating point
  output logic [1:0]             speed_out,
  output logic                   full_duplex_out,
  output logic                   link_up_out,
  output logic                   resolved_valid_out
);

  sae_cfg_if cfg_bus ();

  logic [5:0]  mode_val;
  logic [15:0] peer_q;
  logic [15:0] peer_d;
  logic        page_q;
  logic        page_d;
  logic        able_q;
  logic        done_q;
  logic [15:0] tx_q;
  logic [15:0] tx_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;

  sae_mode_regs u_regs (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .addr_in  (addr_in),
    .wdata_in (wdata_in),
    .wr_in    (wr_in),
    .mode_out (mode_val),
    .cfg      (cfg_bus.regs)
  );

  // ---------------------------------------------------------------------
  // advertised word
  // ---------------------------------------------------------------------
  wire mac_role  = cfg_bus.sgmii_sel && !cfg_bus.role_phy;

  // ack bit is owned by the engine; software's copy of bit 14 is never sent
  wire [15:0] local_live = {cfg_bus.local_word[15],
                            local_ack_in,
                            cfg_bus.local_word[13:0]};

  // stored local word stays untouched, only the link sees the fixed word
  assign tx_d = mac_role ? MAC_FIXED_WORD : local_live;

  // ---------------------------------------------------------------------
  // peer word capture
  // ---------------------------------------------------------------------
  // serial-gmii mode drops reserved bits so stray partner bits cannot be mistaken for
  // function; bit 14 is kept since it is the partner's acknowledge
  wire [15:0] rx_masked = cfg_bus.sgmii_sel ? (rx_word_in & AB_LIVE_MASK) : rx_word_in;

  // no write path exists: the peer register is read-only
  assign peer_d = rx_page_in ? rx_masked : peer_q;

  // ---------------------------------------------------------------------
  // expansion status
  // ---------------------------------------------------------------------
  wire exp_read = rd_in && (addr_in == OFF_EXPANSION);

  // a page arriving in the read cycle survives the clear
  assign page_d = rx_page_in ? 1'b1 : (exp_read ? 1'b0 : page_q);

  wire [15:0] exp_word = {14'h0000, page_q, able_q};

  // ---------------------------------------------------------------------
  // status word
  // ---------------------------------------------------------------------
  wire [15:0] stat_word = 16'(done_q) << STAT_DONE_BIT;

  // ---------------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------------
  wire sel_stat  = (addr_in == OFF_STATUS);
  wire sel_local = (addr_in == OFF_LOCAL);
  wire sel_peer  = (addr_in == OFF_PEER);
  wire sel_exp   = (addr_in == OFF_EXPANSION);
  wire sel_mode  = (addr_in == OFF_MODE);

  // bit 14 of the local register reads the live acknowledge, not the store
  wire [15:0] read_mux = sel_stat  ? stat_word :
                         sel_local ? local_live :
                         sel_peer  ? peer_q :
                         sel_exp   ? exp_word :
                         sel_mode  ? {10'h000, mode_val} :
                         16'h0000;

  // data stands only in the cycle after the strobe
  assign rdata_d = rd_in ? read_mux : 16'h0000;

  // ---------------------------------------------------------------------
  // state
  // ---------------------------------------------------------------------
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      peer_q  <= PEER_RESET;
      page_q  <= 1'b0;
      able_q  <= 1'b0;
      done_q  <= 1'b0;
      tx_q    <= LOCAL_RESET;
      rdata_q <= 16'h0000;
    end
    else
    begin
      peer_q  <= peer_d;
      page_q  <= page_d;
      able_q  <= partner_able_in;
      done_q  <= an_done_in;
      tx_q    <= tx_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------------
  // resolution
  // ---------------------------------------------------------------------
  // the resolver sees the registered done flag so outputs never move ahead
  // of what software can read back
  sae_resolve u_res (
    .clk_in          (clk_in),
    .rst_in          (rst_in),
    .an_done_in      (done_q),
    .peer_word_in    (peer_q),
    .cfg             (cfg_bus.res),
    .speed_out       (speed_out),
    .full_duplex_out (full_duplex_out),
    .link_up_out     (link_up_out),
    .valid_out       (resolved_valid_out)
  );

  assign tx_word_out = tx_q;
  assign rdata_out   = rdata_q;

endmodule

// ### testbench/sae_assertions.sv
// checker for the ability exchange block
// sees only the top ports; attached by the bind at the foot
`timescale 1ns/1ns
module sae_assertions
  import sae_pkg::*;
(
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic [4:0]  addr_in,
  input wire logic [15:0] wdata_in,
  input wire logic        wr_in,
  input wire logic        rd_in,
  input wire logic [15:0] rdata_out,
  input wire logic [15:0] rx_word_in,
  input wire logic        rx_page_in,
  input wire logic        partner_able_in,
  input wire logic        local_ack_in,
  input wire logic        an_done_in,
  input wire logic [15:0] tx_word_out,
  input wire logic [1:0]  speed_out,
  input wire logic        full_duplex_out,
  input wire logic        link_up_out,
  input wire logic        resolved_valid_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (rst_in);
  logic [5:0]  mode_q;
  logic [15:0] peer_q;
  logic [15:0] local_q;
  wire         rd_exp = rd_in && addr_in == OFF_EXPANSION;
  wire         sg_mac = mode_q[0] && !mode_q[5];
  wire         adopt  = mode_q[1:0] == 2'h3;
  wire  [15:0] src    = mode_q[5] ? local_q : peer_q;
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      mode_q  <= 6'h00;
      local_q <= 16'h0001;
      peer_q  <= 16'h0000;
    end
    else
    begin
      if (wr_in && addr_in == OFF_MODE)
        mode_q <= wdata_in[5:0];
      if (wr_in && addr_in == OFF_LOCAL)
        local_q <= wdata_in;
      if (rx_page_in)
        peer_q <= rx_word_in;
    end
  end
  a_mac_fixed: assert property ($past(sg_mac) |-> tx_word_out == MAC_FIXED_WORD)
    else $error("fixed word not advertised");
  a_phy_word_ack: assert property ($past(mode_q[0] && mode_q[5]) |->
    tx_word_out == {$past(local_q[15]), $past(local_ack_in), $past(local_q[13:0])})
    else $error("local word or ack wrong on link");
  a_exp_upper: assert property ($past(rd_exp) |-> rdata_out[15:2] == 14'h0000)
    else $error("expansion upper bits set");
  a_page_set: assert property (rx_page_in ##1 rd_exp |-> ##1 rdata_out[1])
    else $error("page flag not set");
  a_page_clear: assert property (rd_exp && !rx_page_in ##1 !rx_page_in ##1 rd_exp
    && !rx_page_in |-> ##1 !rdata_out[1])
    else $error("page flag not cleared by read");
  a_done_status: assert property ($past(rd_in && addr_in == OFF_STATUS) |->
    rdata_out[5] == $past(an_done_in, 2))
    else $error("done bit wrong");
  a_done_gate: assert property (resolved_valid_out && $past(adopt) |->
    $past(an_done_in, 2))
    else $error("resolved before done");
  a_adopt_res: assert property (resolved_valid_out && $past(adopt) |->
    speed_out == $past(src[11:10]) && full_duplex_out == $past(src[12])
    && link_up_out == $past(src[15]))
    else $error("resolved point differs from ability word");
  a_gig_default: assert property ($past(!mode_q[0]) |->
    speed_out == SPEED_1G && full_duplex_out)
    else $error("non serial mode not gigabit full");
  a_able_flag: assert property ($past(rd_exp) |->
    rdata_out[0] == $past(partner_able_in, 2))
    else $error("partner able flag wrong");
  a_manual_res: assert property ($past(mode_q[1:0] == 2'h1) |->
    speed_out == $past(mode_q[3:2]) && full_duplex_out == !$past(mode_q[4]) && link_up_out)
    else $error("manual speed or duplex not applied");
  cover property (rx_page_in ##1 rd_exp);
  cover property (resolved_valid_out && adopt && !mode_q[5]);
  cover property (resolved_valid_out && adopt && mode_q[5]);
endmodule
bind sae_ability_exchange sae_assertions sae_assertions_inst (.clk_in, .rst_in,
  .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .rx_word_in, .rx_page_in,
  .partner_able_in, .local_ack_in, .an_done_in, .tx_word_out, .speed_out, .full_duplex_out,
  .link_up_out, .resolved_valid_out);

// ### testbench/sae_partner_model.sv
// negotiation link partner and engine model for the engine-side inputs
// assumes the bench asks for one page at a time
`timescale 1ns/1ns
module sae_partner_model
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        send_in,
  input  wire logic        done_in,
  input  wire logic        able_in,
  input  wire logic [15:0] word_in,
  output logic [15:0]      rx_word_out,
  output logic             rx_page_out,
  output logic             able_out,
  output logic             ack_out,
  output logic             done_out
);
  always_ff @(posedge clk_in)
  begin
    rx_page_out <= send_in && !rst_in;
    // word only holds in its page cycle; toggling exposes late sampling
    rx_word_out <= rst_in ? 16'h0000 : (send_in ? word_in : ~rx_word_out);
    able_out    <= able_in && !rst_in;
    ack_out     <= done_in && !rst_in;
    done_out    <= done_in && !rst_in;
  end
endmodule

// ### testbench/tb_top.sv
// bench: register port master and partner model, reads checked through a queue
// assumes design, checker and partner model compiled first
`timescale 1ns/1ns
module tb_top
  import sae_pkg::*;
;
  logic        clk_in, rst_in, wr_in, rd_in, rx_page_in, partner_able_in;
  logic        local_ack_in, an_done_in, full_duplex_out, link_up_out;
  logic        resolved_valid_out, pg_send, an_req, able_req, rd_seen;
  logic [4:0]  addr_in;
  logic [1:0]  speed_out;
  logic [15:0] wdata_in, rdata_out, rx_word_in, tx_word_out, pg_word, lf, w;
  logic [15:0] exp_q[$];
  int          n_errors, total_checks;
  sae_ability_exchange sae_ability_exchange_inst (.clk_in, .rst_in, .addr_in,
    .wdata_in, .wr_in, .rd_in, .rdata_out, .rx_word_in, .rx_page_in,
    .partner_able_in, .local_ack_in, .an_done_in, .tx_word_out, .speed_out,
    .full_duplex_out, .link_up_out, .resolved_valid_out);
  sae_partner_model sae_partner_model_inst (.clk_in, .rst_in, .send_in(pg_send),
    .done_in(an_req), .able_in(able_req), .word_in(pg_word),
    .rx_word_out(rx_word_in), .rx_page_out(rx_page_in), .able_out(partner_able_in),
    .ack_out(local_ack_in), .done_out(an_done_in));
  always #10 clk_in = ~clk_in;
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    // a read whose data never showed up is a mismatch too
    n_errors += exp_q.size();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic bus(input logic [4:0] a, input logic [15:0] d, input logic wr);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= wr;
    rd_in <= !wr;
    @(posedge clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b0;
  endtask
  task automatic rd_reg(input logic [4:0] a, input logic [15:0] exp);
    exp_q.push_back(exp);
    bus(a, 16'h0000, 1'b0);
  endtask
  task automatic send_page(input logic [15:0] v);
    @(posedge clk_in);
    pg_send <= 1'b1;
    pg_word <= v;
    @(posedge clk_in);
    pg_send <= 1'b0;
    an_req <= 1'b1;
  endtask
  task automatic wait_valid();
    for (int i = 0; i <= 20; i++)
    begin
      @(posedge clk_in);
      if (resolved_valid_out === 1'b1)
        break;
      if (i == 20)
      begin
        n_errors++;
        report_and_stop();
      end
    end
  endtask
  // results appear the cycle after the read strobe
  always @(posedge clk_in)
  begin
    if (rd_seen && exp_q.size() > 0)
      check("rdata", rdata_out, exp_q.pop_front());
    rd_seen <= rd_in;
  end
  initial
  begin
    {clk_in, wr_in, rd_in, rd_seen, pg_send, an_req, able_req} = '0;
    {addr_in, wdata_in, pg_word} = '0;
    rst_in = 1'b1;
    lf = 16'hff1e;
    repeat (3) @(posedge clk_in);
    rst_in <= 1'b0;
    rd_reg(OFF_EXPANSION, 16'h0000);
    rd_reg(OFF_MODE, 16'h0000);
    check("speed", speed_out, SPEED_1G);
    able_req <= 1'b1;
    bus(OFF_LOCAL, 16'h9401, 1'b1);
    bus(OFF_MODE, 16'h0003, 1'b1);
    rd_reg(OFF_LOCAL, 16'h9401);
    check("tx_word", tx_word_out, MAC_FIXED_WORD);
    for (int i = 0; i < 4; i++)
    begin
      lf = lfsr(lf);
      w = {lf[15:12], i[1:0], lf[9:0]};
      send_page(w);
      wait_valid();
      check("speed", speed_out, w[11:10]);
      check("duplex", full_duplex_out, w[12]);
      check("link", link_up_out, w[15]);
      rd_reg(OFF_STATUS, 16'h0020);
      an_req <= 1'b0;
      rd_reg(OFF_PEER, w & AB_LIVE_MASK);
      rd_reg(OFF_EXPANSION, 16'h0003);
      rd_reg(OFF_EXPANSION, 16'h0001);
    end
    bus(OFF_PEER, 16'hffff, 1'b1);
    rd_reg(OFF_PEER, w & AB_LIVE_MASK);
    send_page(w);
    rd_reg(OFF_EXPANSION, 16'h0003);
    rd_reg(OFF_EXPANSION, 16'h0001);
    // page and clearing read on one edge: the page must survive
    fork
      send_page(w);
      begin
        @(posedge clk_in);
        rd_reg(OFF_EXPANSION, 16'h0001);
      end
    join
    rd_reg(OFF_EXPANSION, 16'h0003);
    an_req <= 1'b0;
    bus(OFF_LOCAL, 16'h1001, 1'b1);
    bus(OFF_MODE, 16'h0023, 1'b1);
    rd_reg(OFF_MODE, 16'h0023);
    an_req <= 1'b1;
    wait_valid();
    check("speed", speed_out, SPEED_10M);
    check("link", link_up_out, 1'b0);
    check("tx_word", tx_word_out, 16'h5001);
    check("duplex", full_duplex_out, 1'b1);
    rd_reg(OFF_LOCAL, 16'h5001);
    bus(OFF_MODE, 16'h0015, 1'b1);
    repeat (2) @(posedge clk_in);
    check("speed", speed_out, SPEED_100M);
    check("duplex", full_duplex_out, 1'b0);
    check("link", link_up_out, 1'b1);
    check("tx_word", tx_word_out, MAC_FIXED_WORD);
    repeat (3) @(posedge clk_in);
    report_and_stop();
  end
endmodule
